/* core/prp_reset_power_ctrl.sv */
// Function
// RL1: Device makes its own power-on reset; no external pulse needed.
// RL2: Board releases reset pin at least 200 us after power ramps.
// RL3: Board holds reset pin low at least one microsecond.
// RL4: Hardware reset restores all registers and re-latches the straps.
// RL5: Device becomes operational about 200 us after reset pin release.
// RL6: Basic control bit 15 resets only standard registers 0x00 to 0x07.
// RL7: Reset control bit 15 resets circuits and all registers, keeps straps.
// RL8: Reset control bit 14 restarts circuits, registers keep contents.
// RL9: Every software reset or restart completes about 200 us after writing.
// RL10: Host waits 500 us after software reset before next management access.
// RL11: Shared pin is power-down input after reset; output when bit 0 set.
// RL12: Specific control holds global interrupt enable and output polarity.
// RL13: Shared pin held low as input puts device into power-down.
// RL14: Interrupt sources disabled after reset; enables live in 0x12 and 0x13.
// RL15: Enabled interrupt condition drives interrupt output without waiting for a clock.
// RL16: Status shows all pending interrupts; any read clears them all.
// RL17: Pin low or basic bit 11 powers down all but management logic.
// RL18: Bit 14 enables power-save; field 13:12 picks IEEE, active or passive wake.
// RL19: Clearing power-save select powers up and resumes previous state.
// RL20: Straps are captured into negotiation bits during hardware or software reset.
// RL21: Reset and restart bits clear themselves when their sequence completes.
module prp_reset_power_ctrl #(
	parameter int         SETTLE_CYCLES = prp_pkg::SETTLE_CYCLES,
	parameter logic [4:0] PHY_ADDR      = 5'h01
) (
	// Clock and power-on reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Hardware reset pin and straps
	input  wire logic        hwResetN,
	input  wire logic        negotiationEnableStrap,
	input  wire logic [1:0]  negotiationModeStrap,
	// Serial management port
	input  wire logic        mdc,
	input  wire logic        mdioIn,
	output logic             mdioOut,
	output logic             mdioOe,
	// Shared interrupt / power-down pin
	input  wire logic        irqOrPowerdownPinIn,
	output logic             irqOrPowerdownPinOut,
	output logic             irqOrPowerdownPinOe,
	// Interrupt sources
	input  wire logic [15:0] irqEvent,
	// Transceiver control
	output logic             phyReady,
	output logic             circuitResetN,
	output logic             powerDown,
	output logic             wolActive,
	output logic             wolPassive
);
	import prp_pkg::*;

	typedef struct packed {
		prp_seq_t    seq;
		prp_op_t     op;
		logic [2:0]  strap;
		logic [15:0] basic;
		logic [15:0] spec;
		logic [15:0] irqOne;
		logic [15:0] irqTwo;
		logic [15:0] rstCtl;
	} prp_main_state_t;

	prp_main_state_t st_r;
	prp_main_state_t st_nxt;
	logic [4:0]      regAddr;
	logic            wrStrobe;
	logic [15:0]     wrData;
	logic            rdStrobe;
	logic [15:0]     rdData;
	logic            timerStart;
	logic            timerDone;
	logic            readClear;
	logic            irqPending;
	logic            intActive;
	logic            pinPowerDown;

	// Strap order: {enable, mode[1], mode[0]}
	function automatic logic [15:0] basicDefault(input logic [2:0] strap);
		logic [15:0] v;
		v = 16'h0000;
		v[BC_NEGOTIATION_ENABLE_STRAP]  = strap[2];
		v[BC_SPEED]  = strap[1];
		v[BC_DUPLEX] = strap[0];
		return v;
	endfunction

	function automatic prp_main_state_t allDefaults(input prp_main_state_t cur,
		input logic [2:0] strap);
		prp_main_state_t v;
		v = cur;
		v.strap  = strap;
		v.basic  = basicDefault(strap);
		v.spec   = SPEC_CTRL_RST;
		v.irqOne = IRQ_RST;
		v.irqTwo = IRQ_RST;
		v.rstCtl = RESET_CTRL_RST;
		v.op     = OP_NONE;
		return v;
	endfunction

	prp_mgmt_port #(
		.PHY_ADDR (PHY_ADDR)
	) uMgmt (
		.clk      (clk),
		.resetn   (resetn),
		.mdc      (mdc),
		.mdioIn   (mdioIn),
		.mdioOut  (mdioOut),
		.mdioOe   (mdioOe),
		.regAddr  (regAddr),
		.wrStrobe (wrStrobe),
		.wrData   (wrData),
		.rdStrobe (rdStrobe),
		.rdData   (rdData)
	);

	prp_settle_timer #(
		.CYCLES (SETTLE_CYCLES)
	) uTimer (
		.clk    (clk),
		.resetn (resetn),
		.start  (timerStart),
		.busy   (),
		.done   (timerDone)
	);

	always_comb begin
		unique case (regAddr)
			OFS_BASIC_CTRL: rdData = st_r.basic;
			OFS_SPEC_CTRL:  rdData = st_r.spec;
			OFS_IRQ_ONE:    rdData = st_r.irqOne;
			OFS_IRQ_TWO:    rdData = st_r.irqTwo;
			OFS_RESET_CTRL: rdData = st_r.rstCtl;
			default:        rdData = 16'h0000;
		endcase
	end

	assign readClear = rdStrobe && (regAddr == OFS_IRQ_ONE || regAddr == OFS_IRQ_TWO);

	always_comb begin
		st_nxt = st_r;
		timerStart = 1'b0;
		// New events beat the read-clear in the same cycle
		st_nxt.irqOne[15:8] = (readClear ? 8'h00 : st_r.irqOne[15:8])
			| (irqEvent[7:0] & st_r.irqOne[7:0]); // [RL16]
		st_nxt.irqTwo[15:8] = (readClear ? 8'h00 : st_r.irqTwo[15:8])
			| (irqEvent[15:8] & st_r.irqTwo[7:0]); // [RL16]
		if (!hwResetN) begin
			st_nxt = allDefaults(st_r, {negotiationEnableStrap, negotiationModeStrap}); // [RL4] [RL20]
			st_nxt.seq = SEQ_HOLD;
		end else begin
			unique case (st_r.seq)
				SEQ_HOLD: begin
					// Power-on and pin release both pass here
					st_nxt = allDefaults(st_r, {negotiationEnableStrap, negotiationModeStrap}); // [RL1] [RL20]
					st_nxt.seq = SEQ_SETTLE;
					timerStart = 1'b1; // [RL5]
				end
				SEQ_SETTLE: begin
					if (timerDone) begin
						st_nxt.seq = SEQ_RUN; // [RL5]
					end
				end
				SEQ_RUN: begin
					if (timerDone) begin
						st_nxt.op = OP_NONE;
						st_nxt.basic[BC_RESET] = 1'b0; // [RL21]
						st_nxt.rstCtl[RC_GLOBAL] = 1'b0; // [RL21]
						st_nxt.rstCtl[RC_RESTART] = 1'b0; // [RL21]
					end
				end
			endcase
			// Register access stays open in power-down and during soft sequences
			if (wrStrobe && st_r.seq == SEQ_RUN) begin
				unique case (regAddr)
					OFS_BASIC_CTRL: begin
						if (wrData[BC_RESET]) begin
							st_nxt.basic = basicDefault(st_r.strap); // [RL6] [RL20]
							st_nxt.basic[BC_RESET] = 1'b1; // [RL21]
							if (st_r.op == OP_NONE) begin
								st_nxt.op = OP_IEEE;
							end
							timerStart = 1'b1; // [RL9]
						end else begin
							st_nxt.basic = wrData; // [RL17]
						end
					end
					OFS_SPEC_CTRL: st_nxt.spec = wrData; // [RL11] [RL12] [RL18] [RL19]
					OFS_IRQ_ONE:   st_nxt.irqOne[7:0] = wrData[7:0]; // [RL14]
					OFS_IRQ_TWO:   st_nxt.irqTwo[7:0] = wrData[7:0]; // [RL14]
					OFS_RESET_CTRL: begin
						if (wrData[RC_GLOBAL]) begin
							// Latched straps survive, unlike a pin reset
							st_nxt = allDefaults(st_r, st_r.strap); // [RL7] [RL20]
							st_nxt.rstCtl[RC_GLOBAL] = 1'b1; // [RL21]
							st_nxt.op = OP_GLOBAL;
							timerStart = 1'b1; // [RL9]
						end else if (wrData[RC_RESTART]) begin
							st_nxt.rstCtl[RC_RESTART] = 1'b1; // [RL8] [RL21]
							st_nxt.op = OP_RESTART;
							timerStart = 1'b1; // [RL9]
						end else begin
							st_nxt.rstCtl[13:0] = wrData[13:0];
						end
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign phyReady      = (st_r.seq == SEQ_RUN); // [RL5]
	assign circuitResetN = phyReady && st_r.op != OP_GLOBAL && st_r.op != OP_RESTART; // [RL7] [RL8]

	// Pin acts as an input until output enable is set
	assign pinPowerDown = !st_r.spec[SC_INT_OE] && !irqOrPowerdownPinIn; // [RL11] [RL13]
	assign powerDown = pinPowerDown || st_r.basic[BC_POWER_DOWN]
		|| (st_r.spec[SC_PS_EN] && st_r.spec[13:12] == PS_IEEE); // [RL17] [RL18] [RL19]
	assign wolActive  = st_r.spec[SC_PS_EN] && st_r.spec[13:12] == PS_WOL_ACTIVE; // [RL18]
	assign wolPassive = st_r.spec[SC_PS_EN] && st_r.spec[13:12] == PS_WOL_PASSIVE; // [RL18]

	// Raw events feed the pin directly so no clock edge is needed
	assign irqPending = (|st_r.irqOne[15:8]) || (|st_r.irqTwo[15:8])
		|| (|(irqEvent & {st_r.irqTwo[7:0], st_r.irqOne[7:0]})); // [RL15]
	assign intActive = st_r.spec[SC_INT_EN] && irqPending; // [RL12]
	assign irqOrPowerdownPinOe  = st_r.spec[SC_INT_OE]; // [RL11]
	assign irqOrPowerdownPinOut = st_r.spec[SC_INT_POL] ? intActive : !intActive; // [RL12] [RL15]

	// Checks
	logic [CNT_W-1:0] sinceStart_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sinceStart_r <= '0;
		end else if (timerStart) begin
			sinceStart_r <= CNT_W'(1);
		end else if (sinceStart_r != '1) begin
			sinceStart_r <= sinceStart_r + CNT_W'(1);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	settle_interval_a: assert property (timerDone |-> sinceStart_r == CNT_W'(SETTLE_CYCLES)) // [RL5]
		else $error("settle interval length wrong");
	pin_reset_hold_a: assert property (!hwResetN |=> !phyReady && !irqOrPowerdownPinOe) // [RL4]
		else $error("hardware reset did not hold the device");
	ready_after_done_a: assert property ($rose(phyReady) |-> $past(timerDone)) // [RL5]
		else $error("ready rose without settle completion");
	selfclear_done_a: assert property ($fell(st_r.basic[BC_RESET]) && hwResetN |-> $past(timerDone)) // [RL21]
		else $error("basic reset bit cleared early");
	global_reset_a: assert property (wrStrobe && regAddr == OFS_RESET_CTRL && wrData[RC_GLOBAL]
		&& phyReady && hwResetN |=> st_r.spec == SPEC_CTRL_RST && !circuitResetN) // [RL7]
		else $error("global reset left state behind");
	restart_keeps_a: assert property (wrStrobe && regAddr == OFS_RESET_CTRL && !wrData[RC_GLOBAL]
		&& wrData[RC_RESTART] && phyReady && hwResetN |=> $stable(st_r.spec) && !circuitResetN) // [RL8]
		else $error("restart disturbed registers");
	irq_drive_a: assert property (irqOrPowerdownPinOe && intActive
		|-> irqOrPowerdownPinOut == st_r.spec[SC_INT_POL]) // [RL15]
		else $error("interrupt pin not at active level");
	read_clear_a: assert property (readClear && irqEvent == 16'h0000 && hwResetN
		|=> st_r.irqOne[15:8] == 8'h00 && st_r.irqTwo[15:8] == 8'h00) // [RL16]
		else $error("read did not clear pending bits");
	pin_powerdown_a: assert property (!irqOrPowerdownPinOe && !irqOrPowerdownPinIn |-> powerDown) // [RL13]
		else $error("low pin did not power down");
	wake_mode_a: assert property (st_r.spec[SC_PS_EN] && st_r.spec[13:12] == PS_WOL_ACTIVE
		|-> wolActive && !wolPassive) // [RL18]
		else $error("wake mode select wrong");

	// Soft sequences and mode decode
	ieee_keeps_a: assert property (wrStrobe && regAddr == OFS_BASIC_CTRL && wrData[BC_RESET]
		&& phyReady && hwResetN |=> $stable(st_r.spec) && $stable(st_r.irqOne[7:0])) // [RL6]
		else $error("basic reset touched other registers");
	restart_clear_a: assert property ($fell(st_r.rstCtl[RC_RESTART]) && hwResetN
		|-> $past(timerDone)) // [RL21]
		else $error("restart bit cleared early");
	ieee_select_a: assert property (st_r.spec[SC_PS_EN] && st_r.spec[13:12] == PS_IEEE
		|-> powerDown && !wolActive && !wolPassive) // [RL18]
		else $error("power-save select did not power down");
	pin_output_a: assert property (st_r.spec[SC_INT_OE] |-> !pinPowerDown) // [RL11]
		else $error("output pin still read as power-down");
	irq_disabled_a: assert property (irqOrPowerdownPinOe && !st_r.spec[SC_INT_EN]
		|-> irqOrPowerdownPinOut == !st_r.spec[SC_INT_POL]) // [RL12]
		else $error("disabled interrupt reached the pin");

	ready_cov: cover property ($rose(phyReady));
	irq_cov: cover property (irqOrPowerdownPinOe && intActive);
	restart_cov: cover property (st_r.op == OP_RESTART ##1 st_r.op == OP_NONE);
	passive_cov: cover property (wolPassive);
	global_cov: cover property (st_r.op == OP_GLOBAL ##1 st_r.op == OP_NONE);
endmodule // prp_reset_power_ctrl

/* core/prp_pkg.sv */
package prp_pkg;
	// Timing
	localparam int CLK_HZ        = 20_000_000;
	localparam int SETTLE_US     = 200;
	localparam int SETTLE_CYCLES = SETTLE_US * (CLK_HZ / 1_000_000);
	localparam int CNT_W         = 13;

	// Register offsets
	localparam logic [4:0] OFS_BASIC_CTRL = 5'h00;
	localparam logic [4:0] OFS_SPEC_CTRL  = 5'h11;
	localparam logic [4:0] OFS_IRQ_ONE    = 5'h12;
	localparam logic [4:0] OFS_IRQ_TWO    = 5'h13;
	localparam logic [4:0] OFS_RESET_CTRL = 5'h1F;

	// Field positions
	localparam int BC_RESET      = 15;
	localparam int BC_SPEED      = 13;
	localparam int BC_NEGOTIATION_ENABLE_STRAP      = 12;
	localparam int BC_POWER_DOWN = 11;
	localparam int BC_DUPLEX     = 8;
	localparam int SC_INT_OE     = 0;
	localparam int SC_INT_EN     = 1;
	localparam int SC_INT_POL    = 3;
	localparam int SC_PS_EN      = 14;
	localparam int SC_PS_LO      = 12;
	localparam int RC_GLOBAL     = 15;
	localparam int RC_RESTART    = 14;

	// Values after reset
	localparam logic [15:0] SPEC_CTRL_RST  = 16'h0000;
	localparam logic [15:0] IRQ_RST        = 16'h0000;
	localparam logic [15:0] RESET_CTRL_RST = 16'h0000;

	// Power-save select codes
	localparam logic [1:0] PS_IEEE        = 2'h1;
	localparam logic [1:0] PS_WOL_ACTIVE  = 2'h2;
	localparam logic [1:0] PS_WOL_PASSIVE = 2'h3;

	// Management frame
	localparam logic [5:0] PREAMBLE_BITS = 6'h20;
	localparam logic [1:0] MDIO_OP_READ  = 2'h2;
	localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
	localparam logic [4:0] HDR_LAST      = 5'h0C;
	localparam logic [4:0] WR_LAST       = 5'h11;
	localparam logic [4:0] RD_LAST       = 5'h11;

	typedef enum logic [1:0] {
		SEQ_HOLD   = 2'b00,
		SEQ_SETTLE = 2'b01,
		SEQ_RUN    = 2'b10
	} prp_seq_t;

	typedef enum logic [1:0] {
		OP_NONE    = 2'b00,
		OP_IEEE    = 2'b01,
		OP_GLOBAL  = 2'b10,
		OP_RESTART = 2'b11
	} prp_op_t;

	typedef enum logic [1:0] {
		MS_PRE   = 2'b00,
		MS_HDR   = 2'b01,
		MS_WRITE = 2'b10,
		MS_READ  = 2'b11
	} prp_mgmt_t;
endpackage

/* core/prp_settle_timer.sv */
module prp_settle_timer #(
	parameter int CYCLES = prp_pkg::SETTLE_CYCLES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Control
	input  wire logic start,
	output logic      busy,
	output logic      done
);
	import prp_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             busy;
		logic             done;
	} prp_timer_state_t;

	prp_timer_state_t st_r;
	prp_timer_state_t st_nxt;

	// Restart wins, so a new request always gets its full interval
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (start) begin
			st_nxt.cnt = CNT_W'(CYCLES - 1);
			st_nxt.busy = 1'b1;
		end else if (st_r.busy) begin
			if (st_r.cnt <= CNT_W'(1)) begin
				st_nxt.busy = 1'b0;
				st_nxt.done = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign busy = st_r.busy;
	assign done = st_r.done;
endmodule // prp_settle_timer

/* core/prp_mgmt_port.sv */
module prp_mgmt_port #(
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Management pins
	input  wire logic        mdc,
	input  wire logic        mdioIn,
	output logic             mdioOut,
	output logic             mdioOe,
	// Register access
	output logic [4:0]       regAddr,
	output logic             wrStrobe,
	output logic [15:0]      wrData,
	output logic             rdStrobe,
	input  wire logic [15:0] rdData
);
	import prp_pkg::*;

	typedef struct packed {
		prp_mgmt_t   st;
		logic        mdcPrev;
		logic [5:0]  ones;
		logic [4:0]  cnt;
		logic [15:0] shift;
		logic [4:0]  addr;
		logic        wr;
		logic        rd;
		logic        out;
		logic        oe;
	} prp_mgmt_state_t;

	prp_mgmt_state_t st_r;
	prp_mgmt_state_t st_nxt;
	logic [12:0]     hdr;

	always_comb begin
		st_nxt = st_r;
		st_nxt.wr = 1'b0;
		st_nxt.rd = 1'b0;
		st_nxt.mdcPrev = mdc;
		hdr = {st_r.shift[11:0], mdioIn};
		// Capture before the read-clear takes effect
		if (st_r.rd) begin
			st_nxt.shift = rdData;
		end
		if (mdc && !st_r.mdcPrev) begin
			unique case (st_r.st)
				MS_PRE: begin
					if (mdioIn) begin
						if (st_r.ones != PREAMBLE_BITS) begin
							st_nxt.ones = st_r.ones + 6'h01;
						end
					end else if (st_r.ones == PREAMBLE_BITS) begin
						st_nxt.st = MS_HDR;
						st_nxt.cnt = '0;
					end else begin
						st_nxt.ones = '0;
					end
				end
				MS_HDR: begin
					st_nxt.shift = {st_r.shift[14:0], mdioIn};
					st_nxt.cnt = st_r.cnt + 5'h01;
					if (st_r.cnt == HDR_LAST) begin
						st_nxt.addr = hdr[4:0];
						st_nxt.cnt = '0;
						st_nxt.ones = '0;
						st_nxt.st = MS_PRE;
						if (hdr[12] && hdr[9:5] == PHY_ADDR) begin
							if (hdr[11:10] == MDIO_OP_READ) begin
								st_nxt.st = MS_READ;
								st_nxt.rd = 1'b1;
							end else if (hdr[11:10] == MDIO_OP_WRITE) begin
								st_nxt.st = MS_WRITE;
							end
						end
					end
				end
				MS_WRITE: begin
					st_nxt.shift = {st_r.shift[14:0], mdioIn};
					st_nxt.cnt = st_r.cnt + 5'h01;
					if (st_r.cnt == WR_LAST) begin
						st_nxt.wr = 1'b1;
						st_nxt.st = MS_PRE;
					end
				end
				MS_READ: begin
					st_nxt.cnt = st_r.cnt + 5'h01;
					if (st_r.cnt == 5'h00) begin
						st_nxt.oe = 1'b1;
						st_nxt.out = 1'b0;
					end else if (st_r.cnt == RD_LAST) begin
						st_nxt.oe = 1'b0;
						st_nxt.st = MS_PRE;
					end else begin
						st_nxt.out = st_r.shift[15];
						st_nxt.shift = {st_r.shift[14:0], 1'b0};
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign mdioOut  = st_r.out;
	assign mdioOe   = st_r.oe;
	assign regAddr  = st_r.addr;
	assign wrStrobe = st_r.wr;
	assign wrData   = st_r.shift;
	assign rdStrobe = st_r.rd;
endmodule // prp_mgmt_port

/* test/prp_mgmt_host.sv */
module prp_mgmt_host #(
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	// Clock
	input  wire logic clk,
	// Management pins
	output logic      mdc,
	output logic      mdioIn,
	input  wire logic mdioOut,
	input  wire logic mdioOe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hostOe;
	logic hostBit;

	// Pull-up wins once both sides let go
	assign mdioIn = mdioOe ? mdioOut : (hostOe ? hostBit : 1'b1);

	initial begin
		mdc = 1'b0;
		hostOe = 1'b0;
		hostBit = 1'b0;
	end

	// Data moves in the low half so it is settled at the rise
	task automatic bitCyc(input logic drv, input logic b, output logic seen);
		@(posedge clk);
		mdc <= 1'b0;
		hostOe <= drv;
		hostBit <= b;
		repeat (4) @(posedge clk);
		seen = mdioIn;
		mdc <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	// Every frame repeats the preamble; clock stands low between frames
	task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rdat);
		logic [45:0] hdr;
		logic [17:0] tail;
		logic        s;
		hdr = {32'hFFFF_FFFF, 2'b01, rd ? 2'h2 : 2'h1, PHY_ADDR, ra};
		tail = {2'b10, wd};
		rdat = 16'h0000;
		for (int i = 45; i >= 0; i--) begin
			bitCyc(1'b1, hdr[i], s);
		end
		for (int j = 17; j >= 0; j--) begin
			bitCyc(!rd, tail[j], s);
			if (j < 16) begin
				rdat[j] = s;
			end
		end
		@(posedge clk);
		mdc <= 1'b0;
		hostOe <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
endmodule // prp_mgmt_host

/* test/phy_reset_powerdown_irq_tb.sv */
module phy_reset_powerdown_irq_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import prp_pkg::*;
	localparam int SC = 20;
	localparam int HOLDOFF = 10000;
	localparam logic [4:0] PD_REG [4] = '{5'h00, 5'h11, 5'h11, 5'h11};
	localparam logic [15:0] PD_VAL [4] = '{16'h0900, 16'h5000, 16'h6000, 16'h7000};
	localparam logic [2:0] PD_EXP [4] = '{3'h4, 3'h4, 3'h2, 3'h1};
	logic        clk;
	logic        resetn;
	logic        hwResetN;
	logic        anStrap;
	logic [1:0]  modeStrap;
	logic        mdc;
	logic        mdioIn;
	logic        mdioOut;
	logic        mdioOe;
	logic        pinIn;
	logic        pinOut;
	logic        pinOe;
	logic        boardPdLow;
	logic [15:0] irqEvent;
	logic        phyReady;
	logic        circuitResetN;
	logic        powerDown;
	logic        wolActive;
	logic        wolPassive;
	logic [15:0] v;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          lowCnt = 0;
	int          n;

	// Weak pull-up unless the board pulls low
	assign pinIn = pinOe ? pinOut : !boardPdLow;

	prp_reset_power_ctrl #(.SETTLE_CYCLES(SC), .PHY_ADDR(5'h01)) uut (
		.clk(clk), .resetn(resetn), .hwResetN(hwResetN),
		.negotiationEnableStrap(anStrap), .negotiationModeStrap(modeStrap),
		.mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe),
		.irqOrPowerdownPinIn(pinIn), .irqOrPowerdownPinOut(pinOut),
		.irqOrPowerdownPinOe(pinOe), .irqEvent(irqEvent), .phyReady(phyReady),
		.circuitResetN(circuitResetN), .powerDown(powerDown),
		.wolActive(wolActive), .wolPassive(wolPassive));

	prp_mgmt_host #(.PHY_ADDR(5'h01)) host (
		.clk(clk), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(negedge clk) begin
		if (!circuitResetN) begin
			lowCnt++;
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic results;
		$display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		host.xfer(1'b0, ra, d, v);
	endtask

	task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
		host.xfer(1'b1, ra, 16'h0000, v);
		chk(v, exp);
	endtask

	// Edges until ready, bounded
	task automatic settle;
		n = 0;
		while (!phyReady && n < 200) begin
			@(negedge clk);
			n++;
		end
		if (!phyReady) begin
			error_cnt++;
			results();
		end
	endtask

	task automatic pulse(input logic [15:0] ev);
		@(posedge clk);
		irqEvent <= ev;
		#1;
	endtask

	initial begin
		resetn = 1'b0;
		hwResetN = 1'b1;
		anStrap = 1'b1;
		modeStrap = 2'b10;
		boardPdLow = 1'b0;
		irqEvent = 16'h0000;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		settle();
		chk(16'(n inside {[SC + 1:SC + 3]}), 16'h0001);
		rd(OFS_BASIC_CTRL, 16'h3000);
		rd(OFS_SPEC_CTRL, 16'h0000);
		rd(OFS_IRQ_ONE, 16'h0000);
		rd(OFS_IRQ_TWO, 16'h0000);
		rd(OFS_RESET_CTRL, 16'h0000);
		rd(5'h1E, 16'h0000);
		chk(pinOe, 1'b0);
		wr(OFS_SPEC_CTRL, 16'h000A);
		wr(OFS_RESET_CTRL, 16'h1234);
		wr(OFS_BASIC_CTRL, 16'h0100);
		wr(OFS_BASIC_CTRL, 16'h8000);
		repeat (HOLDOFF) @(posedge clk);
		rd(OFS_BASIC_CTRL, 16'h3000);
		rd(OFS_SPEC_CTRL, 16'h000A);
		rd(OFS_RESET_CTRL, 16'h1234);
		// New straps must not be seen until a hardware reset
		anStrap <= 1'b0;
		modeStrap <= 2'b01;
		lowCnt = 0;
		wr(OFS_RESET_CTRL, 16'h4000);
		repeat (HOLDOFF) @(posedge clk);
		chk(16'(lowCnt), 16'(SC));
		rd(OFS_RESET_CTRL, 16'h1234);
		rd(OFS_SPEC_CTRL, 16'h000A);
		lowCnt = 0;
		wr(OFS_RESET_CTRL, 16'h8000);
		repeat (HOLDOFF) @(posedge clk);
		chk(16'(lowCnt), 16'(SC));
		rd(OFS_SPEC_CTRL, 16'h0000);
		rd(OFS_BASIC_CTRL, 16'h3000);
		rd(OFS_RESET_CTRL, 16'h0000);
		wr(OFS_SPEC_CTRL, 16'h000A);
		@(posedge clk);
		hwResetN <= 1'b0;
		repeat (20) @(posedge clk);
		hwResetN <= 1'b1;
		@(negedge clk);
		chk(phyReady, 1'b0);
		settle();
		chk(16'(n inside {[SC:SC + 4]}), 16'h0001);
		rd(OFS_BASIC_CTRL, 16'h0100);
		rd(OFS_SPEC_CTRL, 16'h0000);
		wr(OFS_SPEC_CTRL, 16'h0003);
		wr(OFS_IRQ_ONE, 16'h0001);
		wr(OFS_IRQ_TWO, 16'h0001);
		chk({pinOe, pinOut}, 2'b11);
		pulse(16'h0001);
		chk(pinOut, 1'b0);
		pulse(16'h0000);
		chk(pinOut, 1'b0);
		rd(OFS_IRQ_ONE, 16'h0101);
		chk(pinOut, 1'b1);
		pulse(16'h0101);
		pulse(16'h0000);
		rd(OFS_IRQ_TWO, 16'h0101);
		rd(OFS_IRQ_ONE, 16'h0001);
		pulse(16'h0002);
		chk(pinOut, 1'b1);
		pulse(16'h0000);
		rd(OFS_IRQ_ONE, 16'h0001);
		wr(OFS_SPEC_CTRL, 16'h000B);
		chk(pinOut, 1'b0);
		pulse(16'h0001);
		chk(pinOut, 1'b1);
		pulse(16'h0000);
		rd(OFS_IRQ_ONE, 16'h0101);
		wr(OFS_SPEC_CTRL, 16'h0001);
		pulse(16'h0001);
		chk(pinOut, 1'b1);
		pulse(16'h0000);
		rd(OFS_IRQ_ONE, 16'h0101);
		wr(OFS_SPEC_CTRL, 16'h0000);
		@(posedge clk);
		boardPdLow <= 1'b1;
		@(negedge clk);
		chk(powerDown, 1'b1);
		wr(OFS_IRQ_ONE, 16'h0005);
		rd(OFS_IRQ_ONE, 16'h0005);
		@(posedge clk);
		boardPdLow <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wr(PD_REG[i], PD_VAL[i]);
			chk({powerDown, wolActive, wolPassive}, PD_EXP[i]);
			wr(PD_REG[i], (i == 0) ? 16'h0100 : 16'h0000);
			chk({powerDown, wolActive, wolPassive}, 3'h0);
		end
		rd(OFS_BASIC_CTRL, 16'h0100);
		results();
	end
endmodule // phy_reset_powerdown_irq_tb
